// >>> etcu_checker.sv
// etcu_checker: port assertions for etcu_top
// assumes: one clock, mclk; bound by .* to etcu_top
`timescale 1ns/1ps
module etcu_checker
  import etcu_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic async_clock_select,
  input wire logic [2:0] clock_select_field,
  input wire logic waveform_mode_bit0,
  input wire logic waveform_mode_bit1,
  input wire logic waveform_mode_bit2,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic [1:0] compare_output_mode_b,
  input wire logic force_match_strobe_a,
  input wire logic count_wr,
  input wire logic [7:0] count_wdata,
  input wire logic [2:0] irq_mask_reg,
  input wire logic [7:0] timer_count_r,
  input wire logic [7:0] compare_value_a_r,
  input wire logic [2:0] irq_flag_reg_r,
  input wire logic irq_out_r,
  input wire logic wave_out_a_r,
  input wire logic wave_out_b_r
);
  // ----------------
  // helper state
  // ----------------
  logic [2:0] md;
  logic run, off, run_r, off_r, wr_r;
  assign md = {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0};
  assign run = clock_select_field == 3'h1 && !async_clock_select;
  assign off = clock_select_field == ETCU_CS_OFF;
  always_ff @(posedge mclk)
  begin
    run_r <= run && !sys_rst;
    off_r <= off;
    wr_r <= count_wr;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  AST_STOP: assert property (off && off_r && !count_wr |=> $stable(timer_count_r))
    else $error("counter moved while stopped");
  AST_WR: assert property (count_wr |=> timer_count_r == $past(count_wdata))
    else $error("counter write lost");
  AST_UP: assert property (run && run_r && md == ETCU_WGM_NORMAL && !count_wr
    |=> timer_count_r == $past(timer_count_r) + 8'h01)
    else $error("counter did not step up");
  AST_OVF: assert property (run && run_r && md == ETCU_WGM_NORMAL && !count_wr
    && timer_count_r == ETCU_MAX |=> irq_flag_reg_r[ETCU_FLAG_OVF])
    else $error("overflow flag missing");
  AST_FLAG: assert property ((run && run_r && md == ETCU_WGM_NORMAL && !count_wr
    && !wr_r && timer_count_r == compare_value_a_r) ##1 (run && !count_wr)
    |=> irq_flag_reg_r[ETCU_FLAG_A])
    else $error("match flag missing");
  AST_CTC: assert property (run && run_r && md == ETCU_WGM_CTC && !count_wr && !wr_r
    && timer_count_r == compare_value_a_r |=> timer_count_r == ETCU_BOTTOM)
    else $error("clear on compare missing");
  AST_IRQ: assert property (1'b1
    |=> irq_out_r == |(irq_flag_reg_r & $past(irq_mask_reg)))
    else $error("request not flag and mask");
  AST_FRC: assert property (force_match_strobe_a && md == ETCU_WGM_NORMAL && off
    && off_r && compare_output_mode_a == ETCU_COM_TOGGLE
    |=> wave_out_a_r != $past(wave_out_a_r))
    else $error("force did not toggle");
  AST_NOFRC: assert property (force_match_strobe_a && md[0] && off && off_r
    |=> $stable(wave_out_a_r))
    else $error("force acted in pwm mode");
  AST_COM0: assert property (compare_output_mode_b == ETCU_COM_NONE
    |=> $stable(wave_out_b_r))
    else $error("output moved with mode zero");
endmodule
bind etcu_top etcu_checker chk_u (.*);

// >>> etcu_cpu_model.sv
// etcu_cpu_model: processor side, one-cycle write strobes
// assumes: put is called from one process at a time
`timescale 1ns/1ps
module etcu_cpu_model
(
  input wire logic mclk,
  output logic count_wr,
  output logic [7:0] count_wdata,
  output logic cmp_a_wr,
  output logic cmp_b_wr,
  output logic [7:0] cmp_wdata,
  output logic [2:0] flag_clear_wr,
  output logic [2:0] irq_ack,
  output logic force_match_strobe_a,
  output logic force_match_strobe_b
);
  // ----------------
  // access task
  // ----------------
  task idle(input logic [7:0] d);
    {count_wr, cmp_a_wr, cmp_b_wr, flag_clear_wr, irq_ack} = '0;
    {force_match_strobe_a, force_match_strobe_b} = '0;
    count_wdata = ~d;
    cmp_wdata = ~d;
  endtask
  initial
    idle(8'h5A);
  // kind 0 count, 1 cmp a, 2 cmp b, 3 clear, 4 ack, 5 force
  task put(input int k, input logic [7:0] d);
    @(posedge mclk);
    #1;
    count_wdata = d;
    cmp_wdata = d;
    count_wr = k == 0;
    cmp_a_wr = k == 1;
    cmp_b_wr = k == 2;
    flag_clear_wr = k == 3 ? d[2:0] : 3'h0;
    irq_ack = k == 4 ? d[2:0] : 3'h0;
    {force_match_strobe_b, force_match_strobe_a} = k == 5 ? d[1:0] : 2'h0;
    @(posedge mclk);
    #1;
    idle(d);
  endtask
endmodule

// >>> etcu_pkg.sv
// etcu_pkg: constants and types for the eight bit timer compare unit
// assumes: included before etcu_top and etcu_wave
package etcu_pkg;
  localparam int ETCU_W = 8;
  localparam logic [7:0] ETCU_BOTTOM = 8'h00;
  localparam logic [7:0] ETCU_MAX = 8'hFF;
  localparam logic [7:0] ETCU_CNT_RST = 8'h00;
  localparam logic [7:0] ETCU_CMP_RST = 8'h00;
  localparam logic [2:0] ETCU_CS_OFF = 3'h0;
  localparam logic [2:0] ETCU_WGM_NORMAL = 3'h0;
  localparam logic [2:0] ETCU_WGM_PCPWM = 3'h1;
  localparam logic [2:0] ETCU_WGM_CTC = 3'h2;
  localparam logic [2:0] ETCU_WGM_FAST = 3'h3;
  localparam logic [2:0] ETCU_WGM_PCPWM_A = 3'h5;
  localparam logic [2:0] ETCU_WGM_FAST_A = 3'h7;
  localparam logic [1:0] ETCU_COM_NONE = 2'h0;
  localparam logic [1:0] ETCU_COM_TOGGLE = 2'h1;
  localparam logic [1:0] ETCU_COM_CLEAR = 2'h2;
  localparam logic [1:0] ETCU_COM_SET = 2'h3;
  localparam int ETCU_FLAG_OVF = 0;
  localparam int ETCU_FLAG_A = 1;
  localparam int ETCU_FLAG_B = 2;
  localparam int ETCU_PRE_W = 10;
  localparam logic [9:0] ETCU_PRE_RST = 10'h000;
  localparam int ETCU_SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    ETCU_DIR_UP = 2'b01,
    ETCU_DIR_DOWN = 2'b10
  } etcu_dir_e;
endpackage

// >>> etcu_top.sv
// etcu_top: eight bit timer with two compare channels, control bits as ports
// assumes: processor writes arrive as one-cycle strobes on mclk;
// the crystal input is asynchronous and is synchronised here
`timescale 1ns/1ps
module etcu_top
  import etcu_pkg::*;
#(
  parameter int PRE_W = ETCU_PRE_W
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic async_clock_select,
  input wire logic crystal_in_pin,
  input wire logic [2:0] clock_select_field,
  input wire logic waveform_mode_bit0,
  input wire logic waveform_mode_bit1,
  input wire logic waveform_mode_bit2,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic [1:0] compare_output_mode_b,
  input wire logic force_match_strobe_a,
  input wire logic force_match_strobe_b,
  input wire logic count_wr,
  input wire logic [7:0] count_wdata,
  input wire logic cmp_a_wr,
  input wire logic cmp_b_wr,
  input wire logic [7:0] cmp_wdata,
  input wire logic [2:0] irq_mask_reg,
  input wire logic [2:0] flag_clear_wr,
  input wire logic [2:0] irq_ack,
  output logic [7:0] timer_count_r,
  output logic [7:0] compare_value_a_r,
  output logic [7:0] compare_value_b_r,
  output logic [2:0] irq_flag_reg_r,
  output logic irq_out_r,
  output logic wave_out_a_r,
  output logic wave_out_b_r,
  output logic crystal_out_pin_r
);
  logic [2:0] wgm;
  logic pwm_mode;
  logic non_pwm;
  logic fast_pwm;
  logic top_is_a;
  logic [7:0] top_val;
  logic [1:0] xtal_sync_r;
  logic xtal_prev_r;
  logic xtal_edge;
  logic src_tick;
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [PRE_W-1:0] pre_prev_r;
  logic tick;
  logic [7:0] count_nxt;
  logic [7:0] act_a_r;
  logic [7:0] act_b_r;
  logic [7:0] act_a_nxt;
  logic [7:0] act_b_nxt;
  logic [7:0] buf_a_nxt;
  logic [7:0] buf_b_nxt;
  etcu_dir_e dir_r;
  etcu_dir_e dir_nxt;
  logic block_r;
  logic block_nxt;
  logic match_a;
  logic match_b;
  logic pend_a_r;
  logic pend_b_r;
  logic pend_a_nxt;
  logic pend_b_nxt;
  logic [2:0] flag_nxt;
  logic at_top;
  logic at_bottom;
  logic ovf_evt;
  logic force_a;
  logic force_b;
  logic counting_up;

  function automatic logic div_edge(input logic [PRE_W-1:0] cur,
                                    input logic [PRE_W-1:0] prev,
                                    input int bitno);
    div_edge = cur[bitno] && !prev[bitno];
  endfunction

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign wgm = {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0};
  assign non_pwm = (wgm == ETCU_WGM_NORMAL) || (wgm == ETCU_WGM_CTC);
  assign pwm_mode = !non_pwm;
  assign fast_pwm = (wgm == ETCU_WGM_FAST) || (wgm == ETCU_WGM_FAST_A);
  assign top_is_a = (wgm == ETCU_WGM_CTC) || (wgm == ETCU_WGM_FAST_A)
                    || (wgm == ETCU_WGM_PCPWM_A);
  assign top_val = top_is_a ? act_a_r : ETCU_MAX;
  assign at_top = (timer_count_r == top_val);
  assign at_bottom = (timer_count_r == ETCU_BOTTOM);
  assign counting_up = (dir_r == ETCU_DIR_UP);

  // ----------------------------------------
  // clock source and prescaler
  // ----------------------------------------
  assign xtal_edge = xtal_sync_r[1] && !xtal_prev_r;
  assign src_tick = async_clock_select ? xtal_edge : 1'b1;
  assign pre_nxt = src_tick ? pre_r + 1'b1 : pre_r;

  always_comb
  begin
    case (clock_select_field)
      3'h1: tick = src_tick;
      3'h2: tick = src_tick && div_edge(pre_r, pre_prev_r, 2);
      3'h3: tick = src_tick && div_edge(pre_r, pre_prev_r, 4);
      3'h4: tick = src_tick && div_edge(pre_r, pre_prev_r, 5);
      3'h5: tick = src_tick && div_edge(pre_r, pre_prev_r, 6);
      3'h6: tick = src_tick && div_edge(pre_r, pre_prev_r, 7);
      3'h7: tick = src_tick && div_edge(pre_r, pre_prev_r, PRE_W - 1);
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      xtal_sync_r <= 2'h0;
      xtal_prev_r <= 1'b0;
      pre_r <= '0;
      pre_prev_r <= '0;
    end
    else
    begin
      xtal_sync_r <= {xtal_sync_r[0], crystal_in_pin};
      xtal_prev_r <= xtal_sync_r[1];
      pre_r <= pre_nxt;
      pre_prev_r <= pre_r;
    end
  end

  // ----------------------------------------
  // compare match
  // ----------------------------------------
  assign match_a = tick && !block_r && (timer_count_r == act_a_r);
  assign match_b = tick && !block_r && (timer_count_r == act_b_r);
  assign force_a = force_match_strobe_a && non_pwm;
  assign force_b = force_match_strobe_b && non_pwm;

  // ----------------------------------------
  // counter unit
  // ----------------------------------------
  always_comb
  begin
    count_nxt = timer_count_r;
    dir_nxt = dir_r;
    block_nxt = block_r;
    ovf_evt = 1'b0;
    if (tick)
    begin
      block_nxt = 1'b0;
      if (pwm_mode && !fast_pwm)
      begin
        if (dir_r == ETCU_DIR_UP)
        begin
          if (at_top)
          begin
            dir_nxt = ETCU_DIR_DOWN;
            count_nxt = timer_count_r - 8'h01;
          end
          else
            count_nxt = timer_count_r + 8'h01;
        end
        else
        begin
          if (at_bottom)
          begin
            dir_nxt = ETCU_DIR_UP;
            count_nxt = timer_count_r + 8'h01;
            ovf_evt = 1'b1;
          end
          else
            count_nxt = timer_count_r - 8'h01;
        end
      end
      else
      begin
        dir_nxt = ETCU_DIR_UP;
        if ((wgm == ETCU_WGM_CTC) && match_a)
          count_nxt = ETCU_BOTTOM;
        else if (fast_pwm && at_top)
        begin
          count_nxt = ETCU_BOTTOM;
          ovf_evt = 1'b1;
        end
        else
        begin
          count_nxt = timer_count_r + 8'h01;
          ovf_evt = (timer_count_r == ETCU_MAX);
        end
      end
    end
    if (count_wr)
    begin
      count_nxt = count_wdata;
      block_nxt = 1'b1;
    end
  end

  // ----------------------------------------
  // compare registers
  // ----------------------------------------
  always_comb
  begin
    act_a_nxt = act_a_r;
    act_b_nxt = act_b_r;
    buf_a_nxt = compare_value_a_r;
    buf_b_nxt = compare_value_b_r;
    if (cmp_a_wr)
      buf_a_nxt = cmp_wdata;
    if (cmp_b_wr)
      buf_b_nxt = cmp_wdata;
    if (non_pwm)
    begin
      act_a_nxt = buf_a_nxt;
      act_b_nxt = buf_b_nxt;
    end
    else if (tick && (fast_pwm ? at_top : (at_top || at_bottom)))
    begin
      act_a_nxt = compare_value_a_r;
      act_b_nxt = compare_value_b_r;
    end
  end

  // ----------------------------------------
  // flags and request
  // ----------------------------------------
  always_comb
  begin
    pend_a_nxt = match_a ? 1'b1 : (tick ? 1'b0 : pend_a_r);
    pend_b_nxt = match_b ? 1'b1 : (tick ? 1'b0 : pend_b_r);
    flag_nxt = irq_flag_reg_r & ~(flag_clear_wr | irq_ack);
    if (ovf_evt)
      flag_nxt[ETCU_FLAG_OVF] = 1'b1;
    if (tick && pend_a_r)
      flag_nxt[ETCU_FLAG_A] = 1'b1;
    if (tick && pend_b_r)
      flag_nxt[ETCU_FLAG_B] = 1'b1;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      timer_count_r <= ETCU_CNT_RST;
      dir_r <= ETCU_DIR_UP;
      block_r <= 1'b0;
      act_a_r <= ETCU_CMP_RST;
      act_b_r <= ETCU_CMP_RST;
      compare_value_a_r <= ETCU_CMP_RST;
      compare_value_b_r <= ETCU_CMP_RST;
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
      irq_flag_reg_r <= 3'h0;
      irq_out_r <= 1'b0;
      crystal_out_pin_r <= 1'b0;
    end
    else
    begin
      timer_count_r <= count_nxt;
      dir_r <= dir_nxt;
      block_r <= block_nxt;
      act_a_r <= act_a_nxt;
      act_b_r <= act_b_nxt;
      compare_value_a_r <= buf_a_nxt;
      compare_value_b_r <= buf_b_nxt;
      pend_a_r <= pend_a_nxt;
      pend_b_r <= pend_b_nxt;
      irq_flag_reg_r <= flag_nxt;
      irq_out_r <= |(flag_nxt & irq_mask_reg);
      crystal_out_pin_r <= ~xtal_sync_r[1];
    end
  end

  // ----------------------------------------
  // waveform channels
  // ----------------------------------------
  etcu_wave u_wave_a (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick),
    .match(match_a),
    .force_match(force_a),
    .non_pwm(non_pwm),
    .fast_pwm(fast_pwm),
    .at_bottom(at_bottom),
    .counting_up(counting_up),
    .compare_output_mode(compare_output_mode_a),
    .wave_out_r(wave_out_a_r)
  );

  etcu_wave u_wave_b (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick),
    .match(match_b),
    .force_match(force_b),
    .non_pwm(non_pwm),
    .fast_pwm(fast_pwm),
    .at_bottom(at_bottom),
    .counting_up(counting_up),
    .compare_output_mode(compare_output_mode_b),
    .wave_out_r(wave_out_b_r)
  );
endmodule

// >>> etcu_wave.sv
// etcu_wave: output compare state of one channel
// assumes: match and force strobes arrive as one-cycle pulses on mclk
`timescale 1ns/1ps
module etcu_wave
  import etcu_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic match,
  input wire logic force_match,
  input wire logic non_pwm,
  input wire logic fast_pwm,
  input wire logic at_bottom,
  input wire logic counting_up,
  input wire logic [1:0] compare_output_mode,
  output logic wave_out_r
);
  logic wave_nxt;

  // ----------------------------------------
  // waveform state
  // ----------------------------------------
  always_comb
  begin
    wave_nxt = wave_out_r;
    if (non_pwm)
    begin
      if (match || force_match)
      begin
        case (compare_output_mode)
          ETCU_COM_TOGGLE: wave_nxt = ~wave_out_r;
          ETCU_COM_CLEAR: wave_nxt = 1'b0;
          ETCU_COM_SET: wave_nxt = 1'b1;
          default: wave_nxt = wave_out_r;
        endcase
      end
    end
    else if (compare_output_mode[1])
    begin
      if (fast_pwm)
      begin
        if (match)
          wave_nxt = compare_output_mode[0];
        else if (tick && at_bottom)
          wave_nxt = ~compare_output_mode[0];
      end
      else if (match)
        wave_nxt = counting_up ? compare_output_mode[0] : ~compare_output_mode[0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      wave_out_r <= 1'b0;
    else
      wave_out_r <= wave_nxt;
  end
endmodule

// >>> tb_eight_bit_timer_compare_unit.sv
// tb_eight_bit_timer_compare_unit: directed checks of etcu_top
// assumes: etcu_cpu_model issues every processor write
`timescale 1ns/1ps
module tb_eight_bit_timer_compare_unit
  import etcu_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic async_clock_select = 1'b0;
  logic crystal_in_pin = 1'b0;
  logic [2:0] clock_select_field = 3'h0;
  logic [2:0] md = 3'h0;
  logic [2:0] irq_mask_reg = 3'h0;
  logic [1:0] compare_output_mode_a = 2'h0;
  logic [1:0] compare_output_mode_b = 2'h0;
  wire logic waveform_mode_bit0 = md[0];
  wire logic waveform_mode_bit1 = md[1];
  wire logic waveform_mode_bit2 = md[2];
  logic count_wr, cmp_a_wr, cmp_b_wr, force_match_strobe_a, force_match_strobe_b;
  logic [7:0] count_wdata, cmp_wdata, timer_count_r, compare_value_a_r, compare_value_b_r, v;
  logic [2:0] flag_clear_wr, irq_ack, irq_flag_reg_r;
  logic irq_out_r, wave_out_a_r, wave_out_b_r, crystal_out_pin_r;
  int num_errors = 0;
  int cmp_count = 0;
  always #2.5 mclk = ~mclk;
  etcu_cpu_model cpu_u (.*);
  etcu_top dut_u (.*);
  // ----------------
  // tasks
  // ----------------
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task end_of_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task upto(input logic [7:0] e);
    for (int i = 0; i < 600 && timer_count_r !== e; i++)
      tick(1);
    if (timer_count_r !== e)
    begin
      chk("wait", e, timer_count_r);
      end_of_test();
    end
  endtask
  // ----------------
  // scenarios
  // ----------------
  initial
  begin
    tick(8);
    sys_rst = 1'b0;
    chk("rst", 8'h00, timer_count_r);
    cpu_u.put(0, 8'h10);
    tick(5);
    chk("stop", 8'h10, timer_count_r);
    cpu_u.put(0, 8'hFD);
    clock_select_field = 3'h1;
    upto(8'h02);
    clock_select_field = 3'h0;
    chk("ovf", 8'h07, irq_flag_reg_r);
    irq_mask_reg = 3'h1;
    tick(1);
    chk("irq", 8'h01, irq_out_r);
    cpu_u.put(4, 8'h01);
    chk("ack", 8'h06, irq_flag_reg_r);
    chk("irq", 8'h00, irq_out_r);
    cpu_u.put(3, 8'h06);
    chk("clr", 8'h00, irq_flag_reg_r);
    cpu_u.put(1, 8'h40);
    cpu_u.put(2, 8'h41);
    chk("cmpa", 8'h40, compare_value_a_r);
    cpu_u.put(0, 8'h3E);
    compare_output_mode_a = ETCU_COM_TOGGLE;
    clock_select_field = 3'h1;
    upto(8'h43);
    clock_select_field = 3'h0;
    chk("match", 8'h06, irq_flag_reg_r);
    chk("wave", 8'h01, wave_out_a_r);
    cpu_u.put(3, 8'h06);
    cpu_u.put(0, 8'h40);
    clock_select_field = 3'h1;
    upto(8'h44);
    clock_select_field = 3'h0;
    chk("block", 8'h04, irq_flag_reg_r);
    cpu_u.put(3, 8'h04);
    v = timer_count_r;
    cpu_u.put(5, 8'h03);
    chk("force", 8'h00, {wave_out_b_r, wave_out_a_r});
    chk("nofl", 8'h00, irq_flag_reg_r);
    chk("nold", v, timer_count_r);
    md = ETCU_WGM_FAST;
    tick(2);
    chk("keep", 8'h00, wave_out_a_r);
    cpu_u.put(5, 8'h01);
    chk("pwmf", 8'h00, wave_out_a_r);
    md = ETCU_WGM_CTC;
    cpu_u.put(1, 8'h05);
    cpu_u.put(0, 8'h00);
    clock_select_field = 3'h1;
    repeat (20)
    begin
      tick(1);
      chk("ctc", 8'h00, timer_count_r > 8'h05);
    end
    clock_select_field = 3'h0;
    md = ETCU_WGM_NORMAL;
    cpu_u.put(2, 8'h20);
    md = ETCU_WGM_FAST;
    cpu_u.put(2, 8'h30);
    chk("buf", 8'h30, compare_value_b_r);
    cpu_u.put(0, 8'h10);
    cpu_u.put(3, 8'h07);
    clock_select_field = 3'h1;
    upto(8'h28);
    chk("old", 8'h04, irq_flag_reg_r);
    cpu_u.put(3, 8'h07);
    upto(8'h28);
    chk("new", 8'h03, irq_flag_reg_r);
    upto(8'h38);
    chk("new", 8'h01, irq_flag_reg_r[2]);
    clock_select_field = 3'h0;
    md = ETCU_WGM_PCPWM;
    cpu_u.put(0, 8'hFD);
    clock_select_field = 3'h1;
    upto(8'hFF);
    tick(2);
    chk("down", 8'hFD, timer_count_r);
    clock_select_field = 3'h0;
    md = ETCU_WGM_NORMAL;
    cpu_u.put(0, 8'h00);
    clock_select_field = 3'h2;
    tick(80);
    chk("pre", 8'h0A, timer_count_r);
    clock_select_field = 3'h0;
    cpu_u.put(0, 8'h00);
    async_clock_select = 1'b1;
    clock_select_field = 3'h1;
    repeat (4)
    begin
      tick(4);
      crystal_in_pin = 1'b1;
      tick(4);
      crystal_in_pin = 1'b0;
    end
    tick(6);
    chk("xtal", 8'h04, timer_count_r);
    chk("xout", 8'h01, crystal_out_pin_r);
    end_of_test();
  end
endmodule
